// ==== sisp_pkg.sv ====
// Shared constants and carrier types for the sensor id, status and period
// register bank. Assumes an 8-bit register access port from the serial front end.
package sisp_pkg;

    // Register offsets
    localparam logic [7:0] ADDR_IDENTITY = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h01;
    localparam logic [7:0] ADDR_PERIOD_HIGH = 8'h02;

    // Status field positions
    localparam int STS_INIT_DONE = 7;
    localparam int STS_PIN_LEVEL = 6;
    localparam int STS_TEMP_ERR = 5;
    localparam int STS_SUPPLY_ERR = 4;
    localparam int STS_BAD_CMD_ERR = 3;
    localparam int STS_TEMP_CLR = 2;
    localparam int STS_SUPPLY_CLR = 1;
    localparam int STS_BAD_CMD_CLR = 0;

    // Identity field positions
    localparam int ID_PART_MSB = 7;
    localparam int ID_PART_LSB = 5;
    localparam int ID_VER_MSB = 4;
    localparam int ID_VER_LSB = 0;

    // Sticky flag indices, in status order from bit 5 downward
    localparam int FLAG_TEMP = 2;
    localparam int FLAG_SUPPLY = 1;
    localparam int FLAG_BAD_CMD = 0;
    localparam int NUM_FLAGS = 3;

    // Reset values
    localparam logic [7:0] STATUS_RESET = 8'hC0;
    localparam logic [7:0] PERIOD_HIGH_RESET = 8'h00;
    localparam logic [7:0] PERIOD_LOW_RESET = 8'h3C;

    // Period field layout and limits, one count per second
    localparam int PERIOD_FIELD_W = 4;
    localparam logic [7:0] PERIOD_HIGH_MAX = 8'h0F;
    localparam logic [7:0] PERIOD_HIGH_SUBST = 8'h0F;
    localparam logic signed [15:0] PERIOD_MIN_S = 16'sh0005;
    localparam logic signed [15:0] PERIOD_MAX_S = 16'sh0FFF;

    // Operating modes seen from the configuration register
    typedef enum logic [1:0] {
        MODE_IDLE = 2'b00,
        MODE_SINGLE = 2'b01,
        MODE_CONT = 2'b10,
        MODE_RSVD = 2'b11
    } sisp_mode_t;

    // Register access request from the serial front end
    typedef struct packed {
        logic wrEn;
        logic rdEn;
        logic [7:0] addr;
        logic [7:0] data;
    } sisp_req_t;

    // Error events detected elsewhere in the device
    typedef struct packed {
        logic tempRange;
        logic supplyRange;
        logic badCommand;
    } sisp_events_t;

endpackage

// ==== sisp_sticky_flag.sv ====
// One sticky error flag with a write-one clear.
// Assumes set and clear are single-cycle qualified strobes.
`timescale 1ns/1ns
`default_nettype none
module sisp_sticky_flag (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Set and clear strobes
    input wire logic setEv,
    input wire logic clrEv,
    // Flag state
    output logic flag
);
    logic flag_q;
    logic flag_d;

    always_comb begin
        flag_d = flag_q;
        if (setEv) begin
            flag_d = 1'b1;
        end else if (clrEv) begin
            flag_d = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
        end
    end

    assign flag = flag_q;
endmodule
`default_nettype wire

// ==== sensor_id_status_period_regs.sv ====
// Identity, sensor status and upper period register of the gas sensor bank.
// Assumes a synchronous 8-bit register port from the serial front end and
// that the low period byte and mode register live in a neighbouring block.
`timescale 1ns/1ns
`default_nettype none
module sisp_regs #(
    parameter logic [2:0] PART_TYPE = 3'h5,    // Arbitrary value
    parameter logic [4:0] VERSION = 5'h0A      // Arbitrary value
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Register access
    input wire sisp_pkg::sisp_req_t req,
    output logic [7:0] rdData,
    output logic rdValid,
    // Device state inputs
    input wire logic initOk,
    input wire logic pulse_out_disable_pin,
    input wire sisp_pkg::sisp_events_t events,
    // Neighbouring period and mode logic
    input wire logic [7:0] period_low,
    input wire logic periodLowBadWrite,
    input wire logic [1:0] opMode,
    // Results
    output logic [7:0] period_high,
    output logic [15:0] activePeriod,
    output logic periodLatched,
    output logic [7:0] sensor_status
);
    import sisp_pkg::*;

    // Clamp the concatenated signed period into its legal range
    function automatic logic [15:0] clampPeriod(input logic [7:0] hi, input logic [7:0] lo);
        logic signed [15:0] raw;
        logic [15:0] res;
        raw = {hi, lo};
        res = raw;
        if (raw > PERIOD_MAX_S) begin
            res = PERIOD_MAX_S;
        end else if (raw < PERIOD_MIN_S) begin
            res = PERIOD_MIN_S;
        end
        return res;
    endfunction

    // Register decode
    function automatic logic hitAddr(input sisp_req_t r, input logic [7:0] a);
        return r.addr == a;
    endfunction

    logic wrStatus;
    logic wrHigh;
    logic highBad;
    logic [NUM_FLAGS-1:0] flagSet;
    logic [NUM_FLAGS-1:0] flagClr;
    logic [NUM_FLAGS-1:0] flags;
    logic [7:0] identity_register;
    logic [7:0] statusView;
    logic initDone_q;
    logic pinLevel_q;
    logic [7:0] periodHigh_q;
    logic [7:0] periodHigh_d;
    logic [15:0] activePeriod_q;
    logic periodLatched_q;
    logic [7:0] rdData_q;
    logic [7:0] rdData_d;
    logic rdValid_q;
    logic [7:0] status_q;
    sisp_mode_t modeNow;
    sisp_mode_t mode_q;

    always_comb begin
        identity_register = '0;
        identity_register[ID_PART_MSB:ID_PART_LSB] = PART_TYPE;
        identity_register[ID_VER_MSB:ID_VER_LSB] = VERSION;
    end

    assign wrStatus = req.wrEn && hitAddr(req, ADDR_STATUS);
    assign wrHigh = req.wrEn && hitAddr(req, ADDR_PERIOD_HIGH);
    assign highBad = wrHigh && (req.data > PERIOD_HIGH_MAX);

    assign flagClr[FLAG_TEMP] = wrStatus && req.data[STS_TEMP_CLR];
    assign flagClr[FLAG_SUPPLY] = wrStatus && req.data[STS_SUPPLY_CLR];
    assign flagClr[FLAG_BAD_CMD] = wrStatus && req.data[STS_BAD_CMD_CLR];

    assign flagSet[FLAG_TEMP] = events.tempRange;
    assign flagSet[FLAG_SUPPLY] = events.supplyRange;
    assign flagSet[FLAG_BAD_CMD] = events.badCommand || highBad || periodLowBadWrite;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_FLAGS; gi++) begin : g_flag
            sisp_sticky_flag u_flag (
                .clk(clk),
                .sys_rst(sys_rst),
                .setEv(flagSet[gi]),
                .clrEv(flagClr[gi]),
                .flag(flags[gi])
            );
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            initDone_q <= STATUS_RESET[STS_INIT_DONE];
        end else begin
            initDone_q <= initOk;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pinLevel_q <= STATUS_RESET[STS_PIN_LEVEL];
        end else if (pulse_out_disable_pin != pinLevel_q) begin
            pinLevel_q <= pulse_out_disable_pin;
        end
    end

    always_comb begin
        statusView = '0;
        statusView[STS_INIT_DONE] = initDone_q;
        statusView[STS_PIN_LEVEL] = pinLevel_q;
        statusView[STS_TEMP_ERR] = flags[FLAG_TEMP];
        statusView[STS_SUPPLY_ERR] = flags[FLAG_SUPPLY];
        statusView[STS_BAD_CMD_ERR] = flags[FLAG_BAD_CMD];
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            status_q <= STATUS_RESET;
        end else begin
            status_q <= statusView;
        end
    end

    always_comb begin
        periodHigh_d = periodHigh_q;
        if (highBad) begin
            periodHigh_d = PERIOD_HIGH_SUBST;
        end else if (wrHigh) begin
            periodHigh_d = req.data;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            periodHigh_q <= PERIOD_HIGH_RESET;
        end else begin
            periodHigh_q <= periodHigh_d;
        end
    end

    // Reserved mode code behaves as idle
    always_comb begin
        case (opMode)
            MODE_IDLE: modeNow = MODE_IDLE;
            MODE_SINGLE: modeNow = MODE_SINGLE;
            MODE_CONT: modeNow = MODE_CONT;
            default: modeNow = MODE_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mode_q <= MODE_IDLE;
        end else begin
            mode_q <= modeNow;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            activePeriod_q <= clampPeriod(PERIOD_HIGH_RESET, PERIOD_LOW_RESET);
            periodLatched_q <= 1'b0;
        end else if (mode_q == MODE_IDLE && modeNow == MODE_CONT) begin
            activePeriod_q <= clampPeriod(periodHigh_q, period_low);
            periodLatched_q <= 1'b1;
        end else begin
            periodLatched_q <= 1'b0;
        end
    end

    // Read mux, unmapped addresses read zero
    always_comb begin
        rdData_d = '0;
        if (hitAddr(req, ADDR_IDENTITY)) begin
            rdData_d = identity_register;
        end else if (hitAddr(req, ADDR_STATUS)) begin
            rdData_d = statusView;
        end else if (hitAddr(req, ADDR_PERIOD_HIGH)) begin
            rdData_d = periodHigh_q;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdData_q <= '0;
            rdValid_q <= 1'b0;
        end else begin
            rdValid_q <= req.rdEn;
            if (req.rdEn) begin
                rdData_q <= rdData_d;
            end
        end
    end

    assign rdData = rdData_q;
    assign rdValid = rdValid_q;
    assign period_high = periodHigh_q;
    assign activePeriod = activePeriod_q;
    assign periodLatched = periodLatched_q;
    assign sensor_status = status_q;
endmodule
`default_nettype wire

// ==== sisp_regs_monitor.sv ====
// Port checker for the id, status and period register bank.
// Sees only the top module ports; bound in after the module.
`timescale 1ns/1ns
`default_nettype none
module sisp_regs_monitor #(
    parameter logic [2:0] PART_TYPE = 3'h5,
    parameter logic [4:0] VERSION = 5'h0A
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Inputs
    input wire sisp_pkg::sisp_req_t req,
    input wire logic initOk,
    input wire logic pulse_out_disable_pin,
    input wire sisp_pkg::sisp_events_t events,
    input wire logic periodLowBadWrite,
    // Outputs
    input wire logic [7:0] rdData,
    input wire logic rdValid,
    input wire logic [7:0] period_high,
    input wire logic [15:0] activePeriod,
    input wire logic periodLatched,
    input wire logic [7:0] sensor_status
);
    import sisp_pkg::*;
    logic [1:0] lv;
    logic [2:0] clr;
    assign lv = {initOk, pulse_out_disable_pin};
    assign clr = {3{req.wrEn && req.addr == ADDR_STATUS}} & req.data[2:0];
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    chk_id_fields: assert property (
        req.rdEn && req.addr == ADDR_IDENTITY |=> rdValid && rdData == {PART_TYPE, VERSION})
        else $error("identity read wrong");
    chk_clr_zero: assert property (
        req.rdEn && req.addr == ADDR_STATUS |=> rdData[2:0] == 3'h0)
        else $error("clear bits read nonzero");
    chk_pin_mirror: assert property (
        lv == $past(lv) && lv == $past(lv, 2) |-> sensor_status[7:6] == lv)
        else $error("status bits 7:6 wrong");
    chk_temp_set: assert property (
        events.tempRange |-> ##2 sensor_status[STS_TEMP_ERR])
        else $error("temperature flag not set");
    chk_supply_set: assert property (
        events.supplyRange |-> ##2 sensor_status[STS_SUPPLY_ERR])
        else $error("supply flag not set");
    chk_cmd_set: assert property (
        events.badCommand || periodLowBadWrite |-> ##2 sensor_status[STS_BAD_CMD_ERR])
        else $error("command flag not set");
    chk_clear_works: assert property (
        clr != 3'h0 && events == 3'h0 && !periodLowBadWrite
        |-> ##2 (sensor_status[5:3] & $past(clr, 2)) == 3'h0)
        else $error("flag not cleared");
    chk_sticky_hold: assert property (
        ($past(sensor_status[5:3]) & ~sensor_status[5:3] & ~$past(clr, 2)) == 3'h0)
        else $error("flag dropped without clear");
    chk_high_range: assert property (
        period_high[7:4] == 4'h0)
        else $error("period high out of range");
    chk_period_clamp: assert property (
        activePeriod inside {[16'h0005:16'h0FFF]})
        else $error("active period not clamped");
    chk_latch_pulse: assert property (
        $changed(activePeriod) |-> periodLatched)
        else $error("period changed without latch");
endmodule
bind sisp_regs sisp_regs_monitor #(.PART_TYPE(PART_TYPE), .VERSION(VERSION)) u_mon (
    .clk, .sys_rst, .req, .initOk, .pulse_out_disable_pin, .events, .periodLowBadWrite,
    .rdData, .rdValid, .period_high, .activePeriod, .periodLatched, .sensor_status);
`default_nettype wire

// ==== sisp_host_model.sv ====
// Host controller model issuing register reads and writes.
// Assumes requests are taken on the rising clock edge.
`timescale 1ns/1ns
`default_nettype none
module sisp_host_model (
    // Clock
    input wire logic clk,
    // Register port
    output var sisp_pkg::sisp_req_t req,
    input wire logic [7:0] rdData,
    input wire logic rdValid
);
    import sisp_pkg::*;
    initial req = '{1'b0, 1'b0, 8'hFF, 8'hFF};
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1 req = '{1'b1, 1'b0, a, d};
        @(posedge clk);
        // Idle bus shows inverted values
        #1 req = '{1'b0, 1'b0, ~a, ~d};
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] q, output logic v);
        @(posedge clk);
        #1 req = '{1'b0, 1'b1, a, ~req.data};
        @(posedge clk);
        // Valid stands only in the cycle after the read edge
        #1 req = '{1'b0, 1'b0, ~a, ~req.data};
        q = rdData;
        v = rdValid;
    endtask
endmodule
`default_nettype wire

// ==== sensor_id_status_period_regs_tb_top.sv ====
// Self-checking bench for the id, status and period register bank.
// Assumes the host model drives all register traffic.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin nChecks++; if ((a) !== (e)) begin miscompares++; \
    $display("Error t=%0t got %h exp %h", $time, a, e); end end
module sensor_id_status_period_regs_tb_top;
    import sisp_pkg::*;
    localparam logic [2:0] PT = 3'h5;
    localparam logic [4:0] VR = 5'h0A;
    logic clk = 1'b0;
    logic sysRst = 1'b1;
    sisp_req_t req;
    sisp_events_t events = '0;
    logic [7:0] rdData, periodHigh, sts, q, e;
    logic rdValid, latched, v;
    logic initOk = 1'b1;
    logic pinLvl = 1'b1;
    logic lowBad = 1'b0;
    logic [7:0] periodLow = 8'h3C;
    logic [1:0] opMode = MODE_IDLE;
    logic [15:0] actPer, prevP;
    logic [7:0] his [4] = '{8'h00, 8'h00, 8'h0F, 8'h01};
    logic [7:0] los [4] = '{8'h04, 8'h05, 8'hFF, 8'h23};
    logic [15:0] exps [4] = '{16'h0005, 16'h0005, 16'h0FFF, 16'h0123};
    int miscompares = 0;
    int nChecks = 0;
    always #5 clk = ~clk;
    sisp_host_model host (.clk(clk), .req(req), .rdData(rdData), .rdValid(rdValid));
    sisp_regs #(.PART_TYPE(PT), .VERSION(VR)) DUT (.clk(clk), .sys_rst(sysRst), .req(req),
        .rdData(rdData), .rdValid(rdValid), .initOk(initOk), .pulse_out_disable_pin(pinLvl),
        .events(events), .period_low(periodLow), .periodLowBadWrite(lowBad),
        .opMode(opMode), .period_high(periodHigh), .activePeriod(actPer),
        .periodLatched(latched), .sensor_status(sts));
    task automatic stopTest();
        if (miscompares == 0 && nChecks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic rdChk(input logic [7:0] a, input logic [7:0] x);
        host.rd(a, q, v);
        `CHK(v, 1'b1)
        `CHK(q, x)
    endtask
    task automatic pulse(input logic [2:0] ev, input logic b);
        @(posedge clk);
        #1 events = ev;
        lowBad = b;
        @(posedge clk);
        #1 events = '0;
        lowBad = 1'b0;
    endtask
    // Run is under a hundred cycles; allow 2000 cycles
    initial begin
        #20000;
        miscompares++;
        stopTest();
    end
    initial begin
        repeat (4) @(posedge clk);
        #1 sysRst = 1'b0;
        `CHK(actPer, 16'h003C)
        rdChk(ADDR_STATUS, 8'hC0);
        rdChk(ADDR_PERIOD_HIGH, 8'h00);
        host.wr(ADDR_IDENTITY, 8'h55);
        rdChk(ADDR_IDENTITY, {PT, VR});
        initOk = 1'b0;
        pinLvl = 1'b0;
        rdChk(ADDR_STATUS, 8'h00);
        initOk = 1'b1;
        pulse(3'h7, 1'b0);
        rdChk(ADDR_STATUS, 8'hB8);
        host.wr(ADDR_STATUS, 8'hF8);
        rdChk(ADDR_STATUS, 8'hB8);
        e = 8'hB8;
        for (int i = 0; i < 3; i++) begin
            e[STS_TEMP_ERR - i] = 1'b0;
            host.wr(ADDR_STATUS, 8'h04 >> i);
            rdChk(ADDR_STATUS, e);
        end
        fork
            host.wr(ADDR_STATUS, 8'h07);
            pulse(3'h4, 1'b0);
        join
        rdChk(ADDR_STATUS, 8'hA0);
        pulse(3'h0, 1'b1);
        rdChk(ADDR_STATUS, 8'hA8);
        host.wr(ADDR_STATUS, 8'h07);
        host.wr(ADDR_PERIOD_HIGH, 8'h12);
        rdChk(ADDR_PERIOD_HIGH, 8'h0F);
        rdChk(ADDR_STATUS, 8'h88);
        `CHK(sts, 8'h88)
        host.wr(ADDR_PERIOD_HIGH, 8'h0A);
        rdChk(ADDR_PERIOD_HIGH, 8'h0A);
        `CHK(periodHigh, 8'h0A)
        prevP = 16'h003C;
        for (int i = 0; i < 4; i++) begin
            host.wr(ADDR_PERIOD_HIGH, his[i]);
            periodLow = los[i];
            repeat (2) @(posedge clk);
            #1 `CHK(actPer, prevP)
            opMode = (i == 3) ? MODE_RSVD : MODE_IDLE;
            repeat (2) @(posedge clk);
            #1 opMode = MODE_CONT;
            repeat (4) begin
                @(posedge clk);
                #1;
                if (latched === 1'b1) break;
            end
            `CHK(latched, 1'b1)
            `CHK(actPer, exps[i])
            prevP = exps[i];
        end
        // Single to continuous must not latch
        host.wr(ADDR_PERIOD_HIGH, 8'h02);
        opMode = MODE_SINGLE;
        repeat (2) @(posedge clk);
        #1 opMode = MODE_CONT;
        repeat (3) begin
            @(posedge clk);
            #1 `CHK(latched, 1'b0)
        end
        `CHK(actPer, 16'h0123)
        stopTest();
    end
endmodule
`default_nettype wire
